// ### hw/vmf_pkg.sv
// package for the virtualization instruction fault check block
// assumes a single core clock and a synchronous active-high reset
package vmf_pkg;

  // ----------------------------------------------------------------
  // register map (word offsets in bytes)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CAP = 8'h04;
  localparam logic [7:0] REG_SEG = 8'h08;
  localparam logic [7:0] REG_REQ = 8'h0C;
  localparam logic [7:0] REG_DESC_LO = 8'h10;
  localparam logic [7:0] REG_DESC_HI = 8'h14;
  localparam logic [7:0] REG_EVENT = 8'h18;
  localparam logic [7:0] REG_RESULT = 8'h1C;
  localparam logic [7:0] REG_ERRNUM = 8'h20;
  localparam logic [7:0] REG_FLUSHES = 8'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // ctrl: mode and privilege state of the core
  localparam int CTRL_VIRT_ON = 0;
  localparam int CTRL_NONROOT = 1;
  localparam int CTRL_V86 = 2;
  localparam int CTRL_LONG_ACT = 3;
  localparam int CTRL_CS_LONG = 4;
  localparam int CTRL_REAL = 5;
  localparam int CTRL_CPL_LO = 6;
  localparam int CTRL_CPL_HI = 7;
  // cap: capability bits as seen by software
  localparam int CAP_SEC_TAG = 0;
  localparam int CAP_FLUSH_OP = 1;
  localparam int CAP_TYPE_LO = 4;
  localparam int CAP_TYPE_HI = 7;
  localparam int SEC_TAG_BIT = 37;
  localparam int FLUSH_OP_BIT = 32;
  // seg: memory operand checks
  localparam int SEG_LIMIT_BAD = 0;
  localparam int SEG_UNUSABLE = 1;
  localparam int SEG_EXEC_ONLY = 2;
  localparam int SEG_IS_STACK = 3;
  localparam int SEG_NONCANON = 4;
  localparam int SEG_PAGE_MISS = 5;
  localparam int SEG_PF_LO = 8;
  localparam int SEG_PF_HI = 15;
  // req: instruction launch
  localparam int REQ_GO = 0;
  localparam int REQ_TYPE_LO = 4;
  localparam int REQ_TYPE_HI = 7;
  localparam int REQ_TYPE_HIGH_NZ = 8;
  // event: error event launch
  localparam int EVT_GO = 0;
  localparam int EVT_CODE_LO = 8;
  localparam int EVT_CODE_HI = 12;
  // result layout
  localparam int RES_DONE = 0;
  localparam int RES_FAIL = 1;
  localparam int RES_SUCC = 2;
  localparam int RES_FLT_LO = 4;
  localparam int RES_FLT_HI = 6;
  localparam int RES_CODE_LO = 8;
  localparam int RES_CODE_HI = 15;
  localparam int RES_TAG_LO = 16;
  localparam int RES_TAG_HI = 31;

  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CAP_RST = 32'h0000_0000;
  localparam logic [3:0] FLUSH_TYPE_KEEP_GLOBAL = 4'h3;
  localparam logic [15:0] TAG_ZERO = 16'h0000;
  localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;

  // fault kinds reported in result
  typedef enum logic [2:0] {
    VMF_FLT_NONE,
    VMF_FLT_UD,
    VMF_FLT_GP,
    VMF_FLT_SS,
    VMF_FLT_PF,
    VMF_FLT_EXIT
  } vmf_fault_t;

  // error numbers for the per-guest instruction error field
  localparam logic [7:0] ERR_CALL_IN_ROOT = 8'h01;
  localparam logic [7:0] ERR_CLEAR_BAD_ADDR = 8'h02;
  localparam logic [7:0] ERR_CLEAR_ENTRY_REGION = 8'h03;
  localparam logic [7:0] ERR_LAUNCH_NOT_CLEAR = 8'h04;
  localparam logic [7:0] ERR_RESUME_NOT_LAUNCHED = 8'h05;
  localparam logic [7:0] ERR_RESUME_AFTER_LEAVE = 8'h06;
  localparam logic [7:0] ERR_ENTRY_BAD_CTRL = 8'h07;
  localparam logic [7:0] ERR_ENTRY_BAD_HOST = 8'h08;
  localparam logic [7:0] ERR_LOAD_BAD_ADDR = 8'h09;
  localparam logic [7:0] ERR_LOAD_ENTRY_REGION = 8'h0A;
  localparam logic [7:0] ERR_LOAD_BAD_REV = 8'h0B;
  localparam logic [7:0] ERR_FIELD_UNSUPPORTED = 8'h0C;
  localparam logic [7:0] ERR_FIELD_READ_ONLY = 8'h0D;
  localparam logic [7:0] ERR_ENTER_IN_ROOT = 8'h0F;
  localparam logic [7:0] ERR_DUAL_FIRST = 8'h10;
  localparam logic [7:0] ERR_DUAL_RESERVED = 8'h15;
  localparam logic [7:0] ERR_DUAL_LAST = 8'h19;
  localparam logic [7:0] ERR_SMM_RET_BAD_CTRL = 8'h19;
  localparam logic [7:0] ERR_ENTRY_SS_BLOCK = 8'h1A;
  localparam logic [7:0] ERR_FLUSH_BAD_OPERAND = 8'h1C;
  localparam logic [7:0] ERR_NONE = 8'h00;

  // error event codes written to the event register
  typedef enum logic [4:0] {
    VMF_EV_CALL_IN_ROOT,
    VMF_EV_ENTER_IN_ROOT,
    VMF_EV_CLEAR_BAD_ADDR,
    VMF_EV_CLEAR_ENTRY_REGION,
    VMF_EV_LAUNCH_NOT_CLEAR,
    VMF_EV_RESUME_NOT_LAUNCHED,
    VMF_EV_RESUME_AFTER_LEAVE,
    VMF_EV_LOAD_BAD_ADDR,
    VMF_EV_LOAD_ENTRY_REGION,
    VMF_EV_LOAD_BAD_REV,
    VMF_EV_FIELD_UNSUPPORTED,
    VMF_EV_FIELD_READ_ONLY,
    VMF_EV_ENTRY_BAD_CTRL,
    VMF_EV_ENTRY_BAD_HOST,
    VMF_EV_ENTRY_SS_BLOCK,
    VMF_EV_SMM_RET_BAD_CTRL,
    VMF_EV_DUAL_BAD_EXEC_PTR,
    VMF_EV_DUAL_EXEC_NOT_LAUNCHED,
    VMF_EV_DUAL_EXEC_NOT_REGION,
    VMF_EV_DUAL_NOT_CLEAR,
    VMF_EV_DUAL_BAD_EXIT_CTRL,
    VMF_EV_DUAL_BAD_SEG_REV,
    VMF_EV_DUAL_LEAVE_ACTIVE,
    VMF_EV_DUAL_BAD_FEATURES
  } vmf_event_t;

endpackage : vmf_pkg

// ### hw/vmf_fault_check.sv
// fault check and error numbering unit for virtualization instructions
// assumes classic wishbone slave access, 32-bit data, one core clock
// How it works
// RQ1: type 3 flushes tag bits 15:0, keeps globals
// RQ2: zero tag fails invalid-operand, no invalidation
// RQ3: nonzero privilege level gives protection fault zero
// RQ4: outside 64-bit, segment limit breach gives protection fault
// RQ5: unusable data segment gives protection fault zero
// RQ6: execute-only code source gives protection fault zero
// RQ7: paging miss or violation gives page fault
// RQ8: stack limit or unusable stack gives stack fault
// RQ9: no virtualization or capability bits clear: invalid opcode
// RQ10: real, virtual-8086, compatibility modes: invalid opcode
// RQ11: 64-bit non-canonical: protection or stack fault
// RQ12: failing instructions load an error number
// RQ13: bad flush operand records error 28
// RQ14: call in root 1, enter in root 15
// RQ15: clear bad address 2, entry region 3
// RQ16: launch 4, resume 5, resume after leave 6
// RQ17: pointer load errors 9, 10, 11
// RQ18: unsupported field 12, read-only write 13
// RQ19: entry errors 7, 8, 26
// RQ20: dual-monitor failures use errors 16 to 25
// RQ21: failed management-mode return gives 25, not 7
// RQ22: one failing cause reported, any check order
// RQ23: unsupported type or nonzero high descriptor fails
// RQ24: reserved error numbers are never produced
module vmf_fault_check
  import vmf_pkg::*;
#(
  parameter int TAG_W = 16
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [7:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  output logic flush_o, // one-cycle invalidate strobe
  output logic [TAG_W-1:0] flush_tag_o, // tag to invalidate
  output logic flush_keep_global_o // global translations kept
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] cap, next_cap;
  logic [31:0] seg, next_seg;
  logic [31:0] desc_lo, next_desc_lo;
  logic [31:0] desc_hi, next_desc_hi;
  logic [31:0] result, next_result;
  logic [7:0] errnum, next_errnum;
  logic [15:0] flushes, next_flushes;
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;
  logic flush, next_flush;
  logic [TAG_W-1:0] ftag, next_ftag;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  logic bus_req;
  logic wr_req;
  logic [31:0] wmask;
  logic go_flush;
  logic go_event;
  logic [3:0] req_type;
  logic [15:0] tag_val;
  logic ud_hit;
  logic gp_hit;
  logic ss_hit;
  logic pf_hit;
  logic in_long;
  logic type_ok;
  vmf_fault_t fault;
  logic op_fail;
  logic [7:0] ev_err;

  // wishbone request and byte-lane mask
  assign bus_req = cyc_i && stb_i && !ack;
  assign wr_req = bus_req && we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign go_flush = wr_req && adr_i == REG_REQ && sel_i[0] && dat_i[REQ_GO];
  assign go_event = wr_req && adr_i == REG_EVENT && sel_i[0] && dat_i[EVT_GO];
  assign req_type = dat_i[REQ_TYPE_HI:REQ_TYPE_LO];
  assign tag_val = desc_lo[15:0]; // RQ1
  assign in_long = ctrl[CTRL_LONG_ACT];

  // fault priority: opcode, exit, protection, stack, page
  always_comb begin
    // RQ9 RQ10
    ud_hit = !ctrl[CTRL_VIRT_ON] || ctrl[CTRL_V86] || ctrl[CTRL_REAL]
             || (in_long && !ctrl[CTRL_CS_LONG])
             || !cap[CAP_SEC_TAG] || !cap[CAP_FLUSH_OP];
    gp_hit = ctrl[CTRL_CPL_HI:CTRL_CPL_LO] != 2'h0; // RQ3
    if (!in_long) begin
      // RQ4 RQ5 RQ6
      gp_hit = gp_hit || (!seg[SEG_IS_STACK] && (seg[SEG_LIMIT_BAD] || seg[SEG_UNUSABLE]))
               || seg[SEG_EXEC_ONLY];
      // RQ8
      ss_hit = seg[SEG_IS_STACK] && (seg[SEG_LIMIT_BAD] || seg[SEG_UNUSABLE]);
    end else begin
      // RQ11
      gp_hit = gp_hit || (!seg[SEG_IS_STACK] && seg[SEG_NONCANON]);
      ss_hit = seg[SEG_IS_STACK] && seg[SEG_NONCANON];
    end
    pf_hit = seg[SEG_PAGE_MISS]; // RQ7
    if (ud_hit) begin
      fault = VMF_FLT_UD;
    end else if (ctrl[CTRL_NONROOT]) begin
      fault = VMF_FLT_EXIT;
    end else if (gp_hit) begin
      fault = VMF_FLT_GP;
    end else if (ss_hit) begin
      fault = VMF_FLT_SS;
    end else if (pf_hit) begin
      fault = VMF_FLT_PF;
    end else begin
      fault = VMF_FLT_NONE;
    end
  end

  // operand checks for the type-3 flush
  always_comb begin
    type_ok = req_type == FLUSH_TYPE_KEEP_GLOBAL && !dat_i[REQ_TYPE_HIGH_NZ]
              && cap[CAP_TYPE_LO + 3]; // RQ23
    op_fail = !type_ok || desc_lo[31:16] != 16'h0000 || desc_hi != 32'h0000_0000 // RQ23
              || tag_val == TAG_ZERO; // RQ2
  end

  // error event code to error number, one cause per event
  always_comb begin
    unique case (vmf_event_t'(dat_i[EVT_CODE_HI:EVT_CODE_LO]))
      VMF_EV_CALL_IN_ROOT: ev_err = ERR_CALL_IN_ROOT; // RQ14
      VMF_EV_ENTER_IN_ROOT: ev_err = ERR_ENTER_IN_ROOT; // RQ14
      VMF_EV_CLEAR_BAD_ADDR: ev_err = ERR_CLEAR_BAD_ADDR; // RQ15
      VMF_EV_CLEAR_ENTRY_REGION: ev_err = ERR_CLEAR_ENTRY_REGION; // RQ15
      VMF_EV_LAUNCH_NOT_CLEAR: ev_err = ERR_LAUNCH_NOT_CLEAR; // RQ16
      VMF_EV_RESUME_NOT_LAUNCHED: ev_err = ERR_RESUME_NOT_LAUNCHED; // RQ16
      VMF_EV_RESUME_AFTER_LEAVE: ev_err = ERR_RESUME_AFTER_LEAVE; // RQ16
      VMF_EV_LOAD_BAD_ADDR: ev_err = ERR_LOAD_BAD_ADDR; // RQ17
      VMF_EV_LOAD_ENTRY_REGION: ev_err = ERR_LOAD_ENTRY_REGION; // RQ17
      VMF_EV_LOAD_BAD_REV: ev_err = ERR_LOAD_BAD_REV; // RQ17
      VMF_EV_FIELD_UNSUPPORTED: ev_err = ERR_FIELD_UNSUPPORTED; // RQ18
      VMF_EV_FIELD_READ_ONLY: ev_err = ERR_FIELD_READ_ONLY; // RQ18
      VMF_EV_ENTRY_BAD_CTRL: ev_err = ERR_ENTRY_BAD_CTRL; // RQ19 RQ22
      VMF_EV_ENTRY_BAD_HOST: ev_err = ERR_ENTRY_BAD_HOST; // RQ19 RQ22
      VMF_EV_ENTRY_SS_BLOCK: ev_err = ERR_ENTRY_SS_BLOCK; // RQ19
      VMF_EV_SMM_RET_BAD_CTRL: ev_err = ERR_SMM_RET_BAD_CTRL; // RQ21
      VMF_EV_DUAL_BAD_EXEC_PTR: ev_err = ERR_DUAL_FIRST; // RQ20
      VMF_EV_DUAL_EXEC_NOT_LAUNCHED: ev_err = ERR_DUAL_FIRST + 8'h01; // RQ20
      VMF_EV_DUAL_EXEC_NOT_REGION: ev_err = ERR_DUAL_FIRST + 8'h02; // RQ20
      VMF_EV_DUAL_NOT_CLEAR: ev_err = ERR_DUAL_FIRST + 8'h03; // RQ20
      VMF_EV_DUAL_BAD_EXIT_CTRL: ev_err = ERR_DUAL_FIRST + 8'h04; // RQ20
      VMF_EV_DUAL_BAD_SEG_REV: ev_err = ERR_DUAL_RESERVED + 8'h01; // RQ20 RQ24
      VMF_EV_DUAL_LEAVE_ACTIVE: ev_err = ERR_DUAL_RESERVED + 8'h02; // RQ20
      VMF_EV_DUAL_BAD_FEATURES: ev_err = ERR_DUAL_LAST - 8'h01; // RQ20
      default: ev_err = ERR_NONE; // RQ24
    endcase
  end

  // ----------------------------------------------------------------
  // register and instruction next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_cap = cap;
    next_seg = seg;
    next_desc_lo = desc_lo;
    next_desc_hi = desc_hi;
    next_result = result;
    next_errnum = errnum;
    next_flushes = flushes;
    next_ftag = ftag;
    next_flush = 1'b0;
    next_ack = bus_req;
    next_rdata = BUS_UNMAPPED;
    if (wr_req) begin
      unique case (adr_i)
        REG_CTRL: next_ctrl = (ctrl & ~wmask) | (dat_i & wmask);
        REG_CAP: next_cap = (cap & ~wmask) | (dat_i & wmask);
        REG_SEG: next_seg = (seg & ~wmask) | (dat_i & wmask);
        REG_DESC_LO: next_desc_lo = (desc_lo & ~wmask) | (dat_i & wmask);
        REG_DESC_HI: next_desc_hi = (desc_hi & ~wmask) | (dat_i & wmask);
        default: begin
        end
      endcase
    end
    if (go_flush) begin
      next_result = 32'h0000_0000;
      next_result[RES_DONE] = 1'b1;
      next_result[RES_FLT_HI:RES_FLT_LO] = fault;
      next_result[RES_TAG_HI:RES_TAG_LO] = tag_val;
      if (fault == VMF_FLT_PF) begin
        next_result[RES_CODE_HI:RES_CODE_LO] = seg[SEG_PF_HI:SEG_PF_LO]; // RQ7
      end
      if (fault == VMF_FLT_NONE) begin
        if (op_fail) begin
          next_result[RES_FAIL] = 1'b1; // RQ2 RQ23
          next_errnum = ERR_FLUSH_BAD_OPERAND; // RQ12 RQ13
        end else begin
          next_result[RES_SUCC] = 1'b1; // RQ2
          next_flush = 1'b1; // RQ1
          next_ftag = tag_val[TAG_W-1:0]; // RQ1
          next_flushes = flushes + 16'h0001;
        end
      end
    end else if (go_event && ev_err != ERR_NONE) begin
      next_errnum = ev_err; // RQ12
      next_result = 32'h0000_0000;
      next_result[RES_DONE] = 1'b1;
      next_result[RES_FAIL] = 1'b1;
    end
    if (bus_req && !we_i) begin
      unique case (adr_i)
        REG_CTRL: next_rdata = ctrl;
        REG_CAP: next_rdata = cap;
        REG_SEG: next_rdata = seg;
        REG_DESC_LO: next_rdata = desc_lo;
        REG_DESC_HI: next_rdata = desc_hi;
        REG_RESULT: next_rdata = result;
        REG_ERRNUM: next_rdata = {24'h00_0000, errnum};
        REG_FLUSHES: next_rdata = {16'h0000, flushes};
        default: next_rdata = BUS_UNMAPPED;
      endcase
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
      cap <= CAP_RST;
      seg <= 32'h0000_0000;
      desc_lo <= 32'h0000_0000;
      desc_hi <= 32'h0000_0000;
      result <= 32'h0000_0000;
      errnum <= ERR_NONE;
      flushes <= 16'h0000;
      rdata <= 32'h0000_0000;
      ack <= 1'b0;
      flush <= 1'b0;
      ftag <= '0;
    end else begin
      ctrl <= next_ctrl;
      cap <= next_cap;
      seg <= next_seg;
      desc_lo <= next_desc_lo;
      desc_hi <= next_desc_hi;
      result <= next_result;
      errnum <= next_errnum;
      flushes <= next_flushes;
      rdata <= next_rdata;
      ack <= next_ack;
      flush <= next_flush;
      ftag <= next_ftag;
    end
  end

  // outputs straight from flip-flops
  assign dat_o = rdata;
  assign ack_o = ack;
  assign flush_o = flush;
  assign flush_tag_o = ftag;
  assign flush_keep_global_o = flush; // RQ1

endmodule : vmf_fault_check

// ### test/vmf_fault_check_sva.sv
// assertions on the ports of the fault check unit
// assumes it is bound into vmf_fault_check, one clock, synchronous reset
module vmf_fault_check_sva
  import vmf_pkg::*;
#(
  parameter int TAG_W = 16
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // reset, active high
  input wire logic cyc_i, // bus cycle
  input wire logic stb_i, // bus strobe
  input wire logic we_i, // bus write
  input wire logic [7:0] adr_i, // bus address
  input wire logic [3:0] sel_i, // byte lanes
  input wire logic [31:0] dat_i, // write data
  input wire logic [31:0] dat_o, // read data
  input wire logic ack_o, // acknowledge
  input wire logic flush_o, // invalidate strobe
  input wire logic [TAG_W-1:0] flush_tag_o, // tag to invalidate
  input wire logic flush_keep_global_o // globals kept
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----
  // bus steps
  // ----
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_bad_launch;
    s_take ##0 (we_i && adr_i == REG_REQ && sel_i[0] && dat_i[REQ_GO]
      && (dat_i[REQ_TYPE_HI:REQ_TYPE_LO] != FLUSH_TYPE_KEEP_GLOBAL || dat_i[REQ_TYPE_HIGH_NZ]));
  endsequence
  // ----
  // checks
  // ----
  a_ack_next: assert property (s_take |=> ack_o)
    else $error("access not answered in the next cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
    else $error("acknowledge without a request");
  a_flush_cause: assert property (flush_o |-> ack_o
    && $past(we_i && adr_i == REG_REQ && sel_i[0] && dat_i[REQ_GO]))
    else $error("invalidate without a launch");
  a_flush_type: assert property (s_bad_launch |=> !flush_o)
    else $error("invalidate on a bad type");
  a_keep_global: assert property (flush_keep_global_o == flush_o)
    else $error("global keep flag not with strobe");
  a_tag_nonzero: assert property (flush_o |-> flush_tag_o != '0)
    else $error("invalidate with zero tag");
  a_tag_hold: assert property (!flush_o |-> $stable(flush_tag_o))
    else $error("tag moved without invalidate");
  a_idle_data: assert property (!ack_o |-> dat_o == '0)
    else $error("read data outside acknowledge");
  a_unmapped_zero: assert property (ack_o && !$past(we_i) && $past(adr_i) > REG_FLUSHES |-> dat_o == BUS_UNMAPPED)
    else $error("unmapped read not zero");
endmodule : vmf_fault_check_sva

bind vmf_fault_check vmf_fault_check_sva #(.TAG_W(TAG_W)) vmf_fault_check_sva_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .flush_o(flush_o),
  .flush_tag_o(flush_tag_o), .flush_keep_global_o(flush_keep_global_o)
);

// ### test/vmf_tlb_model.sv
// model of the translation cache that takes invalidate strobes
// assumes one-cycle strobes synchronous to the core clock
module vmf_tlb_model (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset
  input wire logic flush_i, // invalidate strobe
  input wire logic [15:0] tag_i, // tag to invalidate
  input wire logic keep_global_i, // globals survive
  output logic [15:0] count_o, // invalidates that kept globals
  output logic [15:0] bad_o, // invalidates that dropped globals
  output logic [15:0] last_tag_o // tag of latest invalidate
);
  timeunit 1ns;
  timeprecision 100ps;
  // count invalidates and keep the latest tag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 16'h0000;
      bad_o <= 16'h0000;
      last_tag_o <= 16'h0000;
    end else if (flush_i) begin
      last_tag_o <= tag_i;
      if (keep_global_i) begin
        count_o <= count_o + 16'h0001;
      end else begin
        bad_o <= bad_o + 16'h0001;
      end
    end
  end
endmodule : vmf_tlb_model

// ### test/tb_vmf_fault_check.sv
// self-checking bench for the fault check unit
// assumes a one-cycle bus answer and a partner cache model
module tb_vmf_fault_check
  import vmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, flush_o, fkg, hb;
  logic [7:0] adr_i, c, cp, exp_err;
  logic [3:0] sel_i;
  logic [15:0] ftag, pcnt, pbad, ptag, sg;
  logic [31:0] dat_i, dat_o, rd, lo, hi, keep;
  int fails, total_checks, exp_flush;
  logic [7:0] regs [6] = '{REG_CTRL, REG_CAP, REG_RESULT, REG_ERRNUM, REG_FLUSHES, 8'h40};
  logic [7:0] ev_num [24] = '{8'h01, 8'h0F, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0A, 8'h0B, 8'h0C,
    8'h0D, 8'h07, 8'h08, 8'h1A, 8'h19, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18};

  vmf_fault_check #(.TAG_W(16)) vmf_fault_check_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .flush_o(flush_o), .flush_tag_o(ftag), .flush_keep_global_o(fkg));
  vmf_tlb_model vmf_tlb_model_i (.clk_i(clk_i), .rst_i(rst_i), .flush_i(flush_o), .tag_i(ftag),
    .keep_global_i(fkg), .count_o(pcnt), .bad_o(pbad), .last_tag_o(ptag));

  // ----
  // clock, report and bus tasks
  // ----
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled, then released
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      n++;
      if (n > 16) begin
        fails++;
        stop_test();
      end
      @(posedge clk_i);
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // set up, launch a request of type tp and compare with the model
  task run_op(input logic [31:0] l, input logic [31:0] h, input logic b, input logic [3:0] tp);
    int f;
    logic ok, lm;
    lm = c[3] & c[4];
    f = 0;
    if (!c[0] || c[2] || c[5] || (c[3] && !c[4]) || !cp[0] || !cp[1]) f = 1;
    else if (c[1]) f = 5;
    else if (c[7:6] != 2'b00 || sg[2] || (!sg[3] && (lm ? sg[4] : |sg[1:0]))) f = 2;
    else if (sg[3] && (lm ? sg[4] : |sg[1:0])) f = 3;
    else if (sg[5]) f = 4;
    ok = cp[4 + tp] && !b && h == 32'h0 && l[31:16] == 16'h0 && l[15:0] != 16'h0;
    wb(1'b1, REG_CTRL, {24'h0, c}, 4'hF);
    wb(1'b1, REG_CAP, {24'h0, cp}, 4'hF);
    wb(1'b1, REG_SEG, {16'h0, sg}, 4'hF);
    wb(1'b1, REG_DESC_LO, l, 4'hF);
    wb(1'b1, REG_DESC_HI, h, 4'hF);
    wb(1'b1, REG_REQ, {23'h0, b, tp, 4'h1}, 4'hF);
    wb(1'b0, REG_RESULT, 32'h0, 4'hF);
    chk("fault kind", 32'(f), {29'h0, rd[6:4]});
    if (f == 4) chk("page code", {24'h0, sg[15:8]}, {24'h0, rd[15:8]});
    if (f == 0) begin
      chk("op status", ok ? 32'h5 : 32'h3, {29'h0, rd[2:0]});
      if (ok) begin
        exp_flush++;
        chk("result tag", {16'h0, l[15:0]}, {16'h0, rd[31:16]});
        chk("cache tag", {16'h0, l[15:0]}, {16'h0, ptag});
      end else begin
        exp_err = 8'h1C;
      end
    end
    wb(1'b0, REG_ERRNUM, 32'h0, 4'hF);
    chk("error number", {24'h0, exp_err}, rd);
    chk("flush count", 32'(exp_flush), {16'h0, pcnt});
  endtask : run_op

  // ----
  // main sequence
  // ----
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    exp_err = 8'h00;
    void'($urandom(85));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 32'h0, 4'hF);
      chk("reset read", 32'h0, rd);
    end
    $display("test reset values done");
    for (int k = 0; k < 24; k++) begin
      wb(1'b1, REG_EVENT, {19'h0, 5'(k), 8'h01}, 4'hF);
      wb(1'b0, REG_ERRNUM, 32'h0, 4'hF);
      chk("event error", {24'h0, ev_num[k]}, rd);
      wb(1'b0, REG_RESULT, 32'h0, 4'hF);
      chk("event status", 32'h3, {30'h0, rd[1:0]});
    end
    exp_err = 8'h18;
    // codes past the last defined event must leave the error number alone
    for (int k = 24; k < 32; k++) begin
      wb(1'b1, REG_EVENT, {19'h0, 5'(k), 8'h01}, 4'hF);
      wb(1'b0, REG_ERRNUM, 32'h0, 4'hF);
      chk("reserved event", {24'h0, exp_err}, rd);
    end
    $display("test error numbers done");
    c = 8'h19;
    cp = 8'h83;
    sg = 16'h0;
    run_op(32'h0000_1234, 32'h0, 1'b0, 4'h3);
    run_op(32'h0000_0000, 32'h0, 1'b0, 4'h3);
    run_op(32'h0000_5678, 32'h1, 1'b0, 4'h3);
    run_op(32'h0001_5678, 32'h0, 1'b0, 4'h3);
    run_op(32'h0000_5678, 32'h0, 1'b1, 4'h3);
    run_op(32'h0000_5678, 32'h0, 1'b0, 4'h1);
    run_op(32'h0000_FFFF, 32'h0, 1'b0, 4'h3);
    $display("test operand checks done");
    repeat (60) begin
      c = 8'($urandom);
      c[0] = ($urandom % 5) != 0;
      c[1] = ($urandom % 6) == 0;
      c[2] = ($urandom % 8) == 0;
      c[5] = ($urandom % 8) == 0;
      if (($urandom % 3) != 0) c[7:6] = 2'b00;
      cp = {($urandom % 6) != 0, 3'($urandom), 2'b00, ($urandom % 8) != 0, ($urandom % 8) != 0};
      sg = {8'($urandom), 8'($urandom & $urandom & $urandom)} & ((c[3] && c[4]) ? 16'hFF38 : 16'hFF2F);
      lo = {(($urandom % 8) == 0) ? 16'($urandom) : 16'h0, (($urandom % 8) == 0) ? 16'h0 : 16'($urandom)};
      hi = (($urandom % 8) == 0) ? (32'($urandom) | 32'h1) : 32'h0;
      hb = ($urandom % 10) == 0;
      run_op(lo, hi, hb, 4'h3);
    end
    $display("test random faults done");
    wb(1'b0, REG_RESULT, 32'h0, 4'hF);
    keep = rd;
    wb(1'b1, REG_REQ, 32'h0000_0031, 4'hE);
    wb(1'b0, REG_RESULT, 32'h0, 4'hF);
    chk("refused launch", keep, rd);
    wb(1'b0, REG_FLUSHES, 32'h0, 4'hF);
    chk("flush register", 32'(exp_flush), rd);
    chk("globals dropped", 32'h0, {16'h0, pbad});
    $display("test refused launch done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, REG_ERRNUM, 32'h0, 4'hF);
    chk("error after reset", 32'h0, rd);
    $display("test second reset done");
    stop_test();
  end
endmodule : tb_vmf_fault_check
